/* File: hw/cbem_pkg.sv */
// Shared constants and carriers of the branch / jump-else decoder.
// Assumes one 40 MHz core clock and a 32-bit Avalon-MM register bus.
package cbem_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_ILAT   = 8'h04;
  localparam logic [7:0] OFF_IMSKP  = 8'h08;
  localparam logic [7:0] OFF_CURIRQ = 8'h0C;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_STAT   = 8'h14;
  localparam logic [1:0] PAGE_IREG  = 2'h1;
  localparam logic [1:0] PAGE_MREG  = 2'h2;

  // primary_control_register fields and reset
  localparam int          MODE_SIMD_BIT = 0;
  localparam int          MODE_BC1_BIT  = 1;
  localparam int          MODE_BC9_BIT  = 2;
  localparam logic [31:0] MODE_RST      = 32'h0;
  localparam logic [31:0] ILAT_RST      = 32'h0;
  localparam logic [31:0] IMSKP_RST     = 32'h0;

  // Status register field positions
  localparam int STAT_PCS_LSB  = 0;
  localparam int STAT_LOOP_LSB = 8;
  localparam int STAT_ILL_BIT  = 16;

  localparam logic [4:0]  COND_ALWAYS  = 5'h1F;
  localparam logic [3:0]  BCAST_IDX1   = 4'h1;
  localparam logic [3:0]  BCAST_IDX9   = 4'h9;
  localparam logic [31:0] K_NW         = 32'h1;
  localparam logic [31:0] K_SW         = 32'h2;
  localparam logic [31:0] K_BW         = 32'h4;
  localparam logic [31:0] K_BCAST      = 32'h0;
  localparam logic [31:0] RET_OFF      = 32'h1;
  localparam logic [31:0] RET_OFF_DB   = 32'h3;
  localparam logic        DIR_LOAD     = 1'b0;
  localparam logic        DIR_STORE    = 1'b1;

  typedef enum logic {FMT_BRANCH = 1'b0, FMT_JUMP_ELSE = 1'b1} cbem_fmt_t;
  typedef enum logic [1:0] {
    WID_NORMAL = 2'b00, WID_SHORT = 2'b01, WID_BYTE = 2'b10
  } cbem_width_t;
  typedef enum logic {BUS_WAIT = 1'b0, BUS_ACK = 1'b1} cbem_bus_st_t;

  typedef struct packed {
    cbem_fmt_t   fmt;
    logic        variable_length_instr_space;
    logic [31:0] pc;
    logic [4:0]  cond;
    logic        opt_call;
    logic        opt_la;
    logic        opt_db;
    logic        opt_ci;
    logic        rel;
    logic [5:0]  imm6;
    logic [3:0]  br_idx;
    logic [3:0]  br_mod;
    logic [3:0]  acc_idx;
    logic [3:0]  acc_mod;
    logic [3:0]  dreg;
    logic        dir;
    cbem_width_t width;
    logic [38:0] compute;
  } cbem_instr_t;

  typedef struct packed {
    logic        en;
    logic        we;
    logic        compute_en;
    logic        pe_y;
    logic [3:0]  dreg;
    logic [31:0] addr;
  } cbem_mem_t;

  typedef struct packed {
    logic        taken;
    logic        call;
    logic        delayed;
    logic        loop_abort;
    logic        clr_irq;
    logic [31:0] target;
    logic [31:0] ret_addr;
  } cbem_branch_t;

endpackage

/* File: hw/cbem_pe_lane.sv */
// One processing element's else-path transfer and compute request.
// Combinational; the instantiating module registers the result.
`timescale 1ns/10ps
`default_nettype none
module cbem_pe_lane #(
  parameter bit IS_Y = 1'b0
) (
  input  wire logic        en_i,
  input  wire logic        dir_i,
  input  wire logic [38:0] compute_i,
  input  wire logic [3:0]  dreg_i,
  input  wire logic [31:0] base_i,
  input  wire logic [31:0] offset_i,
  output var  cbem_pkg::cbem_mem_t req_o
);

  always_comb begin
    req_o            = '0;
    req_o.en         = en_i;
    req_o.we         = en_i & (dir_i == cbem_pkg::DIR_STORE);
    req_o.compute_en = en_i & (|compute_i);
    req_o.pe_y       = IS_Y;
    req_o.dreg       = dreg_i;
    req_o.addr       = base_i + offset_i;
  end

endmodule // cbem_pe_lane
`default_nettype wire

/* File: hw/cbem_decode.sv */
// Branch clause and conditional jump-with-else decode/execute stage.
// Assumes condition results per element arrive with the instruction.
//
// Summary of operation
// - Four option bits; illegal combos are refused
// - Relative target is pc plus signed imm6
// - Indirect target index plus modify, index kept
// - Condition true jumps, else memory transfer
// - Condition code all ones means unconditional
// - Zero compute field means no compute
// - Jump-else never delayed, aborts or clears
// - Access uses index, then post-modify writeback
// - Direction bit: 0 load, 1 store
// - Jump-else branch uses second generator, access first
// - Jump-else illegal in variable-length space
// - Dual mode jumps when both conditions true
// - Each element does else path independently
// - Second element uses the same dreg, flagged pe_y
// - Second element address offset 1, 2, 4
// - Broadcast read gives second element offset 0
// - Clear-interrupt clears latch and mask pointer
// - Loop-abort pops loop and pc stacks
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module cbem_decode #(
  parameter int NUM_IRQ = 32
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [7:0]              avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic      [31:0]             avs_readdata_o,
  output logic                         avs_waitrequest_o,
  input  wire logic                    instr_valid_i,
  input  wire cbem_pkg::cbem_instr_t   instr_i,
  input  wire logic                    cond_x_i,
  input  wire logic                    cond_y_i,
  input  wire logic [NUM_IRQ-1:0]      irq_set_i,
  output var  cbem_pkg::cbem_branch_t  branch_o,
  output var  cbem_pkg::cbem_mem_t     mem_x_o,
  output var  cbem_pkg::cbem_mem_t     mem_y_o,
  output logic                         pc_push_o,
  output logic                         pc_pop_o,
  output logic                         loop_pop_o,
  output logic                         illegal_o
);

  localparam int IW = $clog2(NUM_IRQ);

  cbem_pkg::cbem_bus_st_t bus_st_q;
  logic [31:0]        mode_q;
  logic [NUM_IRQ-1:0] ilat_q;
  logic [NUM_IRQ-1:0] imskp_q;
  logic [IW-1:0]      cur_irq_q;
  logic [31:0]        pc_q;
  logic [7:0]         pcs_depth_q;
  logic [7:0]         loop_depth_q;
  logic               ill_seen_q;
  logic [31:0]        ireg_q [16];
  logic [31:0]        mreg_q [16];

  logic        wr_fire;
  logic        simd;
  logic        cx_ok;
  logic        cy_ok;
  logic        cond_ok;
  logic        opt_bad;
  logic        illegal;
  logic        go;
  logic        is_je;
  logic        taken;
  logic [3:0]  br_i;
  logic [3:0]  br_m;
  logic [3:0]  acc_i;
  logic [3:0]  acc_m;
  logic [31:0] rel_tgt;
  logic [31:0] ind_tgt;
  logic [31:0] br_ival;
  logic [31:0] acc_base;
  logic [31:0] acc_mval;
  logic [31:0] k_off;
  logic        bcast;
  logic        lane_x_en;
  logic        lane_y_en;
  cbem_pkg::cbem_mem_t req_x;
  cbem_pkg::cbem_mem_t req_y;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Register bus: one wait cycle, then one acknowledge cycle
  assign wr_fire = avs_write_i & (bus_st_q == cbem_pkg::BUS_ACK);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_st_q          <= cbem_pkg::BUS_WAIT;
      avs_waitrequest_o <= 1'b1;
    end else begin
      case (bus_st_q)
        cbem_pkg::BUS_WAIT: begin
          if (avs_read_i | avs_write_i) begin
            bus_st_q          <= cbem_pkg::BUS_ACK;
            avs_waitrequest_o <= 1'b0;
          end
        end
        cbem_pkg::BUS_ACK: begin
          bus_st_q          <= cbem_pkg::BUS_WAIT;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_st_q          <= cbem_pkg::BUS_WAIT;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && bus_st_q == cbem_pkg::BUS_WAIT) begin
      avs_readdata_o <= 32'h0;
      if (avs_address_i[7:6] == cbem_pkg::PAGE_IREG) begin
        avs_readdata_o <= ireg_q[avs_address_i[5:2]];
      end else if (avs_address_i[7:6] == cbem_pkg::PAGE_MREG) begin
        avs_readdata_o <= mreg_q[avs_address_i[5:2]];
      end else begin
        case (avs_address_i)
          cbem_pkg::OFF_MODE:   avs_readdata_o <= mode_q;
          cbem_pkg::OFF_ILAT:   avs_readdata_o <= 32'(ilat_q);
          cbem_pkg::OFF_IMSKP:  avs_readdata_o <= 32'(imskp_q);
          cbem_pkg::OFF_CURIRQ: avs_readdata_o <= 32'(cur_irq_q);
          cbem_pkg::OFF_PC:     avs_readdata_o <= pc_q;
          cbem_pkg::OFF_STAT: begin
            avs_readdata_o[cbem_pkg::STAT_PCS_LSB +: 8]  <= pcs_depth_q;
            avs_readdata_o[cbem_pkg::STAT_LOOP_LSB +: 8] <= loop_depth_q;
            avs_readdata_o[cbem_pkg::STAT_ILL_BIT]       <= ill_seen_q;
          end
          default: avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end

  // Decode
  assign simd  = mode_q[cbem_pkg::MODE_SIMD_BIT];
  assign is_je = (instr_i.fmt == cbem_pkg::FMT_JUMP_ELSE);
  assign cx_ok = (instr_i.cond == cbem_pkg::COND_ALWAYS) | cond_x_i;
  assign cy_ok = (instr_i.cond == cbem_pkg::COND_ALWAYS) | cond_y_i;
  assign cond_ok = simd ? (cx_ok & cy_ok) : cx_ok;
  assign opt_bad = (instr_i.opt_call & (instr_i.opt_la | instr_i.opt_ci)) |
                   (instr_i.opt_la & instr_i.opt_ci);
  assign illegal = is_je ? instr_i.variable_length_instr_space : opt_bad;
  assign go      = instr_valid_i & ~illegal;
  assign taken   = go & cond_ok;

  // Jump-else: branch from second generator, access from first
  assign br_i  = is_je ? {1'b1, instr_i.br_idx[2:0]} : instr_i.br_idx;
  assign br_m  = is_je ? {1'b1, instr_i.br_mod[2:0]} : instr_i.br_mod;
  assign acc_i = {1'b0, instr_i.acc_idx[2:0]};
  assign acc_m = {1'b0, instr_i.acc_mod[2:0]};

  assign rel_tgt  = instr_i.pc + {{26{instr_i.imm6[5]}}, instr_i.imm6};
  assign br_ival  = ireg_q[br_i];
  assign ind_tgt  = br_ival + mreg_q[br_m];
  assign acc_base = ireg_q[acc_i];
  assign acc_mval = mreg_q[acc_m];

  assign bcast = (acc_i == cbem_pkg::BCAST_IDX1 &&
                  mode_q[cbem_pkg::MODE_BC1_BIT]) ||
                 (acc_i == cbem_pkg::BCAST_IDX9 &&
                  mode_q[cbem_pkg::MODE_BC9_BIT]);

  always_comb begin
    case (instr_i.width)
      cbem_pkg::WID_NORMAL: k_off = cbem_pkg::K_NW;
      cbem_pkg::WID_SHORT:  k_off = cbem_pkg::K_SW;
      cbem_pkg::WID_BYTE:   k_off = cbem_pkg::K_BW;
      default:              k_off = cbem_pkg::K_NW;
    endcase
    if (bcast) begin
      k_off = cbem_pkg::K_BCAST;
    end
  end

  // Each element takes the else path on its own false condition
  assign lane_x_en = go & is_je & ~cx_ok;
  assign lane_y_en = go & is_je & simd & ~cy_ok;

  cbem_pe_lane #(.IS_Y(1'b0)) u_lane_x (
    .en_i      (lane_x_en),
    .dir_i     (instr_i.dir),
    .compute_i (instr_i.compute),
    .dreg_i    (instr_i.dreg),
    .base_i    (acc_base),
    .offset_i  (32'h0),
    .req_o     (req_x)
  );

  cbem_pe_lane #(.IS_Y(1'b1)) u_lane_y (
    .en_i      (lane_y_en),
    .dir_i     (instr_i.dir),
    .compute_i (instr_i.compute),
    .dreg_i    (instr_i.dreg),
    .base_i    (acc_base),
    .offset_i  (k_off),
    .req_o     (req_y)
  );

  // Execute results, one cycle after the instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      branch_o   <= '0;
      mem_x_o    <= '0;
      mem_y_o    <= '0;
      pc_push_o  <= 1'b0;
      pc_pop_o   <= 1'b0;
      loop_pop_o <= 1'b0;
      illegal_o  <= 1'b0;
    end else begin
      branch_o.taken      <= taken;
      branch_o.call       <= taken & ~is_je & instr_i.opt_call;
      // Jump-else carries no option flags; only ret_addr still follows opt_db
      branch_o.delayed    <= taken & ~is_je & instr_i.opt_db;
      branch_o.loop_abort <= taken & ~is_je & instr_i.opt_la;
      branch_o.clr_irq    <= taken & ~is_je & instr_i.opt_ci;
      branch_o.target     <= instr_i.rel ? rel_tgt : ind_tgt;
      branch_o.ret_addr   <= instr_i.pc + (instr_i.opt_db ?
                             cbem_pkg::RET_OFF_DB : cbem_pkg::RET_OFF);
      mem_x_o    <= req_x;
      mem_y_o    <= req_y;
      pc_push_o  <= taken & ~is_je & instr_i.opt_call;
      pc_pop_o   <= taken & ~is_je & instr_i.opt_la;
      loop_pop_o <= taken & ~is_je & instr_i.opt_la;
      illegal_o  <= instr_valid_i & illegal;
    end
  end

  // Program counter and stack depths
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q         <= 32'h0;
      pcs_depth_q  <= 8'h0;
      loop_depth_q <= 8'h0;
      ill_seen_q   <= 1'b0;
    end else begin
      if (wr_fire && avs_address_i == cbem_pkg::OFF_PC) begin
        pc_q <= be_merge(pc_q, avs_writedata_i, avs_byteenable_i);
      end else if (taken) begin
        pc_q <= instr_i.rel ? rel_tgt : ind_tgt;
      end
      if (wr_fire && avs_address_i == cbem_pkg::OFF_STAT) begin
        pcs_depth_q  <= avs_writedata_i[cbem_pkg::STAT_PCS_LSB +: 8];
        loop_depth_q <= avs_writedata_i[cbem_pkg::STAT_LOOP_LSB +: 8];
        // A refusal in the same cycle as a status write still sticks
        ill_seen_q   <= avs_writedata_i[cbem_pkg::STAT_ILL_BIT] |
                        (instr_valid_i & illegal);
      end else begin
        if (taken && !is_je && instr_i.opt_call) begin
          pcs_depth_q <= pcs_depth_q + 8'h1;
        end else if (taken && !is_je && instr_i.opt_la &&
                     pcs_depth_q != 8'h0) begin
          pcs_depth_q <= pcs_depth_q - 8'h1;
        end
        if (taken && !is_je && instr_i.opt_la && loop_depth_q != 8'h0) begin
          loop_depth_q <= loop_depth_q - 8'h1;
        end
        if (instr_valid_i && illegal) begin
          ill_seen_q <= 1'b1;
        end
      end
    end
  end

  // Mode and interrupt bookkeeping; new latch events win over clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q    <= cbem_pkg::MODE_RST;
      ilat_q    <= NUM_IRQ'(cbem_pkg::ILAT_RST);
      imskp_q   <= NUM_IRQ'(cbem_pkg::IMSKP_RST);
      cur_irq_q <= '0;
    end else begin
      if (wr_fire && avs_address_i == cbem_pkg::OFF_MODE) begin
        mode_q <= be_merge(mode_q, avs_writedata_i, avs_byteenable_i);
      end
      if (wr_fire && avs_address_i == cbem_pkg::OFF_CURIRQ) begin
        cur_irq_q <= avs_writedata_i[IW-1:0];
      end
      if (wr_fire && avs_address_i == cbem_pkg::OFF_ILAT) begin
        ilat_q <= avs_writedata_i[NUM_IRQ-1:0] | irq_set_i;
      end else if (taken && !is_je && instr_i.opt_ci) begin
        ilat_q <= (ilat_q & ~(NUM_IRQ'(1) << cur_irq_q)) | irq_set_i;
      end else begin
        ilat_q <= ilat_q | irq_set_i;
      end
      if (wr_fire && avs_address_i == cbem_pkg::OFF_IMSKP) begin
        imskp_q <= avs_writedata_i[NUM_IRQ-1:0];
      end else if (taken && !is_je && instr_i.opt_ci) begin
        imskp_q <= imskp_q & ~(NUM_IRQ'(1) << cur_irq_q);
      end
    end
  end

  // Index and modify registers; post-modify wins over a bus write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        ireg_q[i] <= 32'h0;
        mreg_q[i] <= 32'h0;
      end
    end else begin
      if (wr_fire && avs_address_i[7:6] == cbem_pkg::PAGE_IREG) begin
        ireg_q[avs_address_i[5:2]] <= be_merge(ireg_q[avs_address_i[5:2]],
                                               avs_writedata_i,
                                               avs_byteenable_i);
      end
      if (wr_fire && avs_address_i[7:6] == cbem_pkg::PAGE_MREG) begin
        mreg_q[avs_address_i[5:2]] <= be_merge(mreg_q[avs_address_i[5:2]],
                                               avs_writedata_i,
                                               avs_byteenable_i);
      end
      if (lane_x_en || lane_y_en) begin
        ireg_q[acc_i] <= acc_base + acc_mval;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  opt_refuse_a: assert property (
    instr_valid_i && !is_je && opt_bad |=> illegal_o && !branch_o.taken)
    else $error("illegal branch options not refused");
  rel_target_a: assert property (
    taken && instr_i.rel |=> branch_o.target == $past(rel_tgt))
    else $error("relative target wrong");
  ind_keep_a: assert property (
    taken && !is_je && !instr_i.rel |=>
      branch_o.target == $past(ind_tgt) &&
      ireg_q[$past(br_i)] == $past(br_ival))
    else $error("indirect target wrong or index changed");
  else_path_a: assert property (
    go && is_je && !cx_ok |=> mem_x_o.en && !branch_o.taken)
    else $error("else path not taken");
  cond_always_a: assert property (
    go && instr_i.cond == cbem_pkg::COND_ALWAYS |=> branch_o.taken)
    else $error("unconditional branch not taken");
  no_compute_a: assert property (
    lane_x_en && instr_i.compute == '0 |=> mem_x_o.en && !mem_x_o.compute_en)
    else $error("compute issued for zero field");
  je_plain_a: assert property (
    go && is_je |=> !branch_o.delayed && !branch_o.loop_abort &&
                    !branch_o.clr_irq && !pc_push_o)
    else $error("jump-else carried options");
  post_mod_a: assert property (
    lane_x_en |=> mem_x_o.addr == $past(acc_base) &&
                  ireg_q[$past(acc_i)] == $past(acc_base) + $past(acc_mval))
    else $error("post-modify addressing wrong");
  dir_map_a: assert property (
    lane_x_en |=> mem_x_o.we == $past(instr_i.dir))
    else $error("transfer direction wrong");
  variable_length_instr_space_refuse_a: assert property (
    instr_valid_i && is_je && instr_i.variable_length_instr_space |=>
      illegal_o && !mem_x_o.en && !branch_o.taken)
    else $error("jump-else accepted in variable-length space");
  simd_and_a: assert property (
    go && simd && instr_i.cond != cbem_pkg::COND_ALWAYS &&
    (cond_x_i != cond_y_i) |=> !branch_o.taken)
    else $error("dual mode jump without both conditions");
  pe_y_addr_a: assert property (
    lane_y_en |=> mem_y_o.pe_y && mem_y_o.addr == $past(acc_base) +
                  $past(k_off))
    else $error("second element address wrong");
  bcast_same_a: assert property (
    lane_y_en && bcast |=> mem_y_o.addr == mem_x_o.addr || !mem_x_o.en)
    else $error("broadcast address differs");
  bus_ack_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus not answered in one cycle");

  je_jump_c: cover property (go && is_je && cond_ok);
  simd_split_c: cover property (lane_y_en && !lane_x_en);
  call_db_c: cover property (taken && instr_i.opt_call && instr_i.opt_db);
  ci_jump_c: cover property (taken && instr_i.opt_ci);

endmodule // cbem_decode
`default_nettype wire

/* File: tb/cbem_fetch_model.sv */
// Fetch path model: presents one instruction with its condition results.
// Assumes one caller of issue() at a time, on the core clock.
`timescale 1ns/10ps
`default_nettype none
module cbem_fetch_model (
  input  wire logic                 clk_i,
  output var  logic                 valid_o,
  output var  cbem_pkg::cbem_instr_t instr_o,
  output var  logic                 cond_x_o,
  output var  logic                 cond_y_o
);
  initial begin
    valid_o = 1'b0;
    instr_o = '0;
    cond_x_o = 1'b0;
    cond_y_o = 1'b0;
  end
  task automatic issue(input cbem_pkg::cbem_instr_t i, input logic cx,
                       input logic cy);
    @(posedge clk_i);
    valid_o <= 1'b1;
    instr_o <= i;
    cond_x_o <= cx;
    cond_y_o <= cy;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Stale word is not left standing once the slot is over
    instr_o <= ~i;
    cond_x_o <= ~cx;
    cond_y_o <= ~cy;
  endtask
endmodule // cbem_fetch_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the branch and jump-else decoder.
// Assumes the fetch model drives the instruction port.
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {
    cbem_pkg::cbem_instr_t ins;
    logic                  cx;
    logic                  cy;
    logic [4:0]            flg;
    logic [31:0]           tgt;
    logic                  mx;
    logic [3:0]            pul;
  } cbem_row_t;
  logic clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, irq_set_i, q, base;
  logic instr_valid_i, cond_x_i, cond_y_i;
  logic pc_push_o, pc_pop_o, loop_pop_o, illegal_o;
  cbem_pkg::cbem_instr_t instr_i, ins;
  cbem_pkg::cbem_branch_t branch_o;
  cbem_pkg::cbem_mem_t mem_x_o, mem_y_o;
  cbem_row_t rows [11];
  int err_count = 0;
  int n_tests = 0;

  cbem_decode dut (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .cond_x_i(cond_x_i), .cond_y_i(cond_y_i),
    .irq_set_i(irq_set_i), .branch_o(branch_o), .mem_x_o(mem_x_o),
    .mem_y_o(mem_y_o), .pc_push_o(pc_push_o), .pc_pop_o(pc_pop_o),
    .loop_pop_o(loop_pop_o), .illegal_o(illegal_o));
  cbem_fetch_model fm (.clk_i(clk_i), .valid_o(instr_valid_i),
    .instr_o(instr_i), .cond_x_o(cond_x_i), .cond_y_o(cond_y_i));

  always #12.5 clk_i = ~clk_i;

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      final_report();
    end
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  function automatic cbem_pkg::cbem_instr_t mk(input logic f,
      input logic [4:0] c, input logic [3:0] o, input logic r,
      input logic v, input logic d);
    cbem_pkg::cbem_instr_t i;
    i = '0;
    i.fmt = cbem_pkg::cbem_fmt_t'(f);
    i.variable_length_instr_space = v;
    i.pc = 32'h100;
    i.cond = c;
    {i.opt_call, i.opt_la, i.opt_db, i.opt_ci} = o;
    i.rel = r;
    i.imm6 = 6'h3E;
    i.br_idx = 4'h8;
    i.br_mod = 4'h9;
    i.acc_idx = 4'h1;
    i.acc_mod = 4'h1;
    i.dreg = 4'h3;
    i.dir = d;
    return i;
  endfunction

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0;
    irq_set_i = 32'h0;
    rows = '{
      '{mk(0,5'h1F,4'h0,1,0,0),0,0,5'h10,32'hFE,0,4'h0},
      '{mk(0,5'h1F,4'h0,0,0,0),0,0,5'h10,32'h310,0,4'h0},
      '{mk(0,5'h1F,4'hA,1,0,0),0,0,5'h1C,32'hFE,0,4'h8},
      '{mk(0,5'h1F,4'hC,1,0,0),0,0,5'h00,32'h0,0,4'h1},
      '{mk(0,5'h1F,4'h5,1,0,0),0,0,5'h00,32'h0,0,4'h1},
      '{mk(0,5'h1F,4'h6,1,0,0),0,0,5'h16,32'hFE,0,4'h6},
      '{mk(0,5'h05,4'h0,1,0,0),0,0,5'h00,32'h0,0,4'h0},
      '{mk(1,5'h05,4'h0,0,0,1),1,0,5'h10,32'h310,0,4'h0},
      '{mk(1,5'h05,4'h0,0,0,1),0,0,5'h00,32'h0,1,4'h0},
      '{mk(1,5'h1F,4'h0,0,1,1),0,0,5'h00,32'h0,0,4'h1},
      '{mk(1,5'h1F,4'h0,0,0,1),0,0,5'h10,32'h310,0,4'h0}};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk(avs_waitrequest_o, 32'h1);
    chk({branch_o.taken, mem_x_o.en, mem_y_o.en, pc_push_o, illegal_o},
        32'h0);
    bus(0, cbem_pkg::OFF_MODE, 32'h0, q);
    chk(q, cbem_pkg::MODE_RST);
    bus(1, 8'h44, 32'h200, q);
    bus(1, 8'h84, 32'h4, q);
    bus(1, 8'h60, 32'h300, q);
    bus(1, 8'hA4, 32'h10, q);
    bus(1, 8'hF0, 32'h5A, q);
    bus(0, 8'hF0, 32'h0, q);
    chk(q, 32'h0);
    foreach (rows[i]) begin
      fm.issue(rows[i].ins, rows[i].cx, rows[i].cy);
      #1 chk({branch_o.taken, branch_o.call, branch_o.delayed,
              branch_o.loop_abort, branch_o.clr_irq}, rows[i].flg);
      chk({pc_push_o, pc_pop_o, loop_pop_o, illegal_o}, rows[i].pul);
      if (rows[i].flg[4]) chk(branch_o.target, rows[i].tgt);
      if (rows[i].flg[3]) chk(branch_o.ret_addr, 32'h103);
      chk(mem_x_o.en, rows[i].mx);
      chk(mem_y_o.en, 32'h0);
      if (rows[i].mx) chk(mem_x_o.addr, 32'h200);
      if (rows[i].mx) chk(mem_x_o.we, cbem_pkg::DIR_STORE);
    end
    bus(0, 8'h44, 32'h0, q);
    chk(q, 32'h204);
    bus(0, 8'h60, 32'h0, q);
    chk(q, 32'h300);
    bus(0, cbem_pkg::OFF_STAT, 32'h0, q);
    chk(q, 32'h1 << cbem_pkg::STAT_ILL_BIT);
    // Dual element: widths, then broadcast on the first index
    bus(1, cbem_pkg::OFF_MODE, 32'h1, q);
    bus(1, 8'h44, 32'h400, q);
    base = 32'h400;
    for (int w = 0; w < 4; w++) begin
      ins = mk(1, 5'h05, 4'h0, 0, 0, 0);
      ins.width = cbem_pkg::cbem_width_t'(w % 3);
      ins.compute = 39'(w);
      if (w == 3) bus(1, cbem_pkg::OFF_MODE, 32'h3, q);
      fm.issue(ins, 1'b0, 1'b0);
      #1 chk(mem_x_o.addr, base);
      chk(mem_y_o.addr, base + 32'((w == 3) ? 0 : (1 << w)));
      chk({mem_y_o.en, mem_y_o.pe_y, mem_y_o.we}, 32'h6);
      chk(mem_x_o.compute_en, 32'(w != 0));
      base = base + 32'h4;
    end
    bus(1, cbem_pkg::OFF_MODE, 32'h1, q);
    fm.issue(mk(1, 5'h05, 4'h0, 0, 0, 0), 1'b1, 1'b0);
    #1 chk({branch_o.taken, mem_x_o.en, mem_y_o.en}, 32'h1);
    fm.issue(mk(1, 5'h05, 4'h0, 0, 0, 0), 1'b1, 1'b1);
    #1 chk(branch_o.taken, 32'h1);
    // Clear-interrupt jump drops the current interrupt's state
    bus(1, cbem_pkg::OFF_CURIRQ, 32'h3, q);
    bus(1, cbem_pkg::OFF_IMSKP, 32'h8, q);
    @(posedge clk_i);
    irq_set_i <= 32'h8;
    @(posedge clk_i);
    irq_set_i <= 32'h0;
    bus(0, cbem_pkg::OFF_ILAT, 32'h0, q);
    chk(q, 32'h8);
    fm.issue(mk(0, 5'h1F, 4'h1, 1, 0, 0), 1'b0, 1'b0);
    #1 chk(branch_o.clr_irq, 32'h1);
    bus(0, cbem_pkg::OFF_ILAT, 32'h0, q);
    chk(q, 32'h0);
    bus(0, cbem_pkg::OFF_IMSKP, 32'h0, q);
    chk(q, 32'h0);
    final_report();
  end
endmodule // tb
`default_nettype wire
